// [acs_pkg.sv]
package acs_pkg;

  localparam int ACS_WORD_W = 16;
  localparam int ACS_DATA_W = 14;
  localparam int ACS_ADC_W = 12;
  localparam int ACS_NUM_COEF = 10;
  localparam int ACS_CNT_W = 16;
  localparam int ACS_CONV_CYCLES = 64;
  localparam int ACS_STEP_CYCLES = 32;

  // Frame address field: top two bits of every 16-bit word written in
  localparam logic [1:0] ACS_ADDR_CAL = 2'h2;
  localparam logic [1:0] ACS_ADDR_CTRL = 2'h3;

  // Readback select codes
  localparam logic [1:0] ACS_RD_ADC = 2'h0;
  localparam logic [1:0] ACS_RD_TEST = 2'h1;
  localparam logic [1:0] ACS_RD_CAL = 2'h2;
  localparam logic [1:0] ACS_RD_STATUS = 2'h3;

  // Calibration target codes
  localparam logic [1:0] ACS_TGT_ALL = 2'h0;
  localparam logic [1:0] ACS_TGT_GAIN_OFF = 2'h1;
  localparam logic [1:0] ACS_TGT_OFF = 2'h2;
  localparam logic [1:0] ACS_TGT_GAIN = 2'h3;

  // Coefficient array order: gain, offset, then the eight DAC words
  localparam logic [3:0] ACS_IDX_GAIN = 4'h0;
  localparam logic [3:0] ACS_IDX_OFF = 4'h1;
  localparam logic [3:0] ACS_IDX_DAC0 = 4'h2;
  localparam logic [3:0] ACS_IDX_LAST = 4'h9;
  localparam logic [2:0] ACS_DAC_LAST_SUB = 3'h7;

  // Control word field positions
  localparam int ACS_B_PM = 8;
  localparam int ACS_B_RDSEL = 6;
  localparam int ACS_B_MODE = 5;
  localparam int ACS_B_CONV = 4;
  localparam int ACS_B_KIND = 3;
  localparam int ACS_B_TGT = 1;
  localparam int ACS_B_LAUNCH = 0;

  localparam logic [1:0] ACS_STAT_ID = 2'h3;
  localparam logic [3:0] ACS_LAST_BIT = 4'hF;
  localparam logic [1:0] ACS_SYNC_RESET = 2'h0;

  typedef enum logic [1:0] {
    ACS_ST_IDLE,
    ACS_ST_DAC,
    ACS_ST_GAIN,
    ACS_ST_OFFSET
  } acs_step_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [13:0] data;
  } acs_frame_t;

  typedef struct packed {
    logic [1:0] power_saving;
    logic [1:0] readback_select;
    logic mode;
    logic cal_kind_select;
    logic [1:0] cal_target;
    logic cal_launch;
  } acs_ctrl_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [14:0] shift_in;
    logic [14:0] shift_out;
    acs_frame_t word;
    logic toggle;
    logic dout;
  } acs_link_st_t;

  typedef struct packed {
    acs_ctrl_t ctrl;
    logic conv;
    logic [15:0] conv_cnt;
    acs_step_t step;
    logic [2:0] sub;
    logic [15:0] step_cnt;
    logic [1:0] cal_tgt;
    logic cal_sys;
    logic [3:0] ptr;
    logic [9:0][13:0] coef;
    logic [11:0] adc;
    logic [2:0] tog_s;
    logic [1:0] fr_s;
    logic [15:0] rd_word;
    logic busy;
  } acs_core_st_t;

endpackage : acs_pkg

// [acs_link.sv]
`timescale 1ns/1ps
module acs_link (
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic frame_n,
  input wire logic din,
  input wire logic [acs_pkg::ACS_WORD_W-1:0] rd_word,
  output logic dout,
  output acs_pkg::acs_frame_t rx_word,
  output logic rx_toggle
);
  import acs_pkg::*;

  acs_link_st_t s_q;
  acs_link_st_t s_d;

  // rd_word is sampled only on the first edge of a frame; the core holds it still while a frame is open
  always_comb begin
    s_d = s_q;
    if (!frame_n) begin
      s_d.cnt = s_q.cnt + 4'h1;
      s_d.shift_in = {s_q.shift_in[13:0], din};
      if (s_q.cnt == 4'h0) begin
        {s_d.dout, s_d.shift_out} = rd_word;
      end else begin
        {s_d.dout, s_d.shift_out} = {s_q.shift_out, 1'b0};
      end
      if (s_q.cnt == ACS_LAST_BIT) begin
        s_d.word = {s_q.shift_in, din};
        s_d.toggle = !s_q.toggle;
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.dout;
  assign rx_word = s_q.word;
  assign rx_toggle = s_q.toggle;

endmodule : acs_link

// [acs_core.sv]
// Operation
// - Self mode: target picks DAC/gain/offset order
// - System mode: same order with system steps
// - All-zero selection runs full internal calibration
// - Sixteen-bit status word is read only
// - Status bits other than 7..6 are zero after power-up
// - Bits 15 and 13..10 always zero
// - Bit 14 shows conversion or calibration busy
// - Bits 9..8 return power saving field
// - Bits 7..6 read as ones
// - Bit 5 interface mode, cleared each read
// - Bit 3 shows self or system calibration
// - Bit 0 high while calibration runs
// - Bits 2..1 return calibration target field
// - Ten coefficients: eight DAC, offset, gain
// - All coefficients writable and readable
// - Calibration runs update coefficients automatically
// - Target field selects coefficient subset
// - Same decoding for coefficient reads and writes
// - Launch bit starts calibration, self-clears
// - Control write resets pointer; access advances it
// - Coefficient reads carry two leading zeros
`timescale 1ns/1ps
module acs_core #(
  parameter int CONV_CYCLES = acs_pkg::ACS_CONV_CYCLES,
  parameter int STEP_CYCLES = acs_pkg::ACS_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic din,
  output logic dout,
  input wire logic [acs_pkg::ACS_ADC_W-1:0] adc_code,
  input wire logic [acs_pkg::ACS_DATA_W-1:0] cal_measure,
  output logic busy_q,
  output acs_pkg::acs_step_t cal_step_q,
  output logic cal_system_q,
  output logic [1:0] power_saving_q
);
  import acs_pkg::*;

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  logic [1:0] rst_sync_q;
  logic rst_n;
  acs_core_st_t s_q;
  acs_core_st_t s_d;
  acs_frame_t link_word;
  logic link_tog;
  logic ev;
  logic cal_wr;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= ACS_SYNC_RESET;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  acs_link u_link (
    .sclk(sclk),
    .rst_n(rst_n),
    .frame_n(frame_n),
    .din(din),
    .rd_word(s_q.rd_word),
    .dout(dout),
    .rx_word(link_word),
    .rx_toggle(link_tog)
  );

  function automatic acs_step_t first_step(input logic [1:0] tgt);
    case (tgt)
      ACS_TGT_ALL: first_step = ACS_ST_DAC;
      ACS_TGT_GAIN_OFF: first_step = ACS_ST_GAIN;
      ACS_TGT_OFF: first_step = ACS_ST_OFFSET;
      default: first_step = ACS_ST_GAIN;
    endcase
  endfunction : first_step

  function automatic acs_step_t next_step(input acs_step_t st, input logic [1:0] tgt);
    case (st)
      ACS_ST_DAC: next_step = ACS_ST_GAIN;
      ACS_ST_GAIN: next_step = (tgt == ACS_TGT_ALL || tgt == ACS_TGT_GAIN_OFF) ? ACS_ST_OFFSET : ACS_ST_IDLE;
      default: next_step = ACS_ST_IDLE;
    endcase
  endfunction : next_step

  function automatic logic [3:0] first_ptr(input logic [1:0] tgt);
    first_ptr = (tgt == ACS_TGT_OFF) ? ACS_IDX_OFF : ACS_IDX_GAIN;
  endfunction : first_ptr

  function automatic logic [3:0] last_ptr(input logic [1:0] tgt);
    case (tgt)
      ACS_TGT_ALL: last_ptr = ACS_IDX_LAST;
      ACS_TGT_GAIN_OFF: last_ptr = ACS_IDX_OFF;
      ACS_TGT_OFF: last_ptr = ACS_IDX_OFF;
      default: last_ptr = ACS_IDX_GAIN;
    endcase
  endfunction : last_ptr

  // Wraps to the first register when the selected subset is exhausted
  function automatic logic [3:0] ptr_next(input logic [3:0] p, input logic [1:0] tgt);
    ptr_next = (p == last_ptr(tgt)) ? first_ptr(tgt) : p + 4'h1;
  endfunction : ptr_next

  function automatic logic [3:0] step_idx(input acs_step_t st, input logic [2:0] sub);
    case (st)
      ACS_ST_DAC: step_idx = ACS_IDX_DAC0 + {1'b0, sub};
      ACS_ST_OFFSET: step_idx = ACS_IDX_OFF;
      default: step_idx = ACS_IDX_GAIN;
    endcase
  endfunction : step_idx

  function automatic logic [15:0] status_word(input acs_core_st_t x);
    status_word = {1'b0, x.busy, 4'h0, x.ctrl.power_saving, ACS_STAT_ID,
                   x.ctrl.mode, 1'b0, x.ctrl.cal_kind_select,
                   x.ctrl.cal_target, x.ctrl.cal_launch};
  endfunction : status_word

  function automatic logic [15:0] read_word(input acs_core_st_t x);
    case (x.ctrl.readback_select)
      ACS_RD_ADC: read_word = {4'h0, x.adc};
      ACS_RD_CAL: read_word = {2'b00, x.coef[x.ptr]};
      ACS_RD_STATUS: read_word = status_word(x);
      default: read_word = '0;
    endcase
  endfunction : read_word

  assign ev = s_q.tog_s[2] ^ s_q.tog_s[1];
  // Coefficient writes are locked out while a calibration owns the array
  assign cal_wr = ev && link_word.addr == ACS_ADDR_CAL && !s_q.ctrl.cal_launch;

  always_comb begin
    s_d = s_q;
    s_d.tog_s = {s_q.tog_s[1:0], link_tog};
    s_d.fr_s = {s_q.fr_s[0], frame_n};

    if (s_q.conv) begin
      if (s_q.conv_cnt == CONV_LAST) begin
        s_d.conv = 1'b0;
        s_d.adc = adc_code;
      end else begin
        s_d.conv_cnt = s_q.conv_cnt + 16'h1;
      end
    end

    if (s_q.step != ACS_ST_IDLE) begin
      s_d.step_cnt = s_q.step_cnt + 16'h1;
      if (s_q.step_cnt == STEP_LAST) begin
        s_d.step_cnt = '0;
        s_d.coef[step_idx(s_q.step, s_q.sub)] = cal_measure;
        if (s_q.step == ACS_ST_DAC && s_q.sub != ACS_DAC_LAST_SUB) begin
          s_d.sub = s_q.sub + 3'h1;
        end else begin
          s_d.sub = '0;
          s_d.step = next_step(s_q.step, s_q.cal_tgt);
          if (s_d.step == ACS_ST_IDLE) begin
            s_d.ctrl.cal_launch = 1'b0;
          end
        end
      end
    end

    // Frame handling comes last, but its launch and convert starts are gated on the old state, so a same-cycle hardware end wins
    if (ev) begin
      s_d.ctrl.mode = 1'b0;
      if (s_q.ctrl.readback_select == ACS_RD_CAL || cal_wr) begin
        s_d.ptr = ptr_next(s_q.ptr, s_q.ctrl.cal_target);
      end
      if (cal_wr) begin
        s_d.coef[s_q.ptr] = link_word.data;
      end
      if (link_word.addr == ACS_ADDR_CTRL) begin
        s_d.ctrl.power_saving = link_word.data[ACS_B_PM +: 2];
        s_d.ctrl.readback_select = link_word.data[ACS_B_RDSEL +: 2];
        s_d.ctrl.mode = link_word.data[ACS_B_MODE];
        s_d.ctrl.cal_kind_select = link_word.data[ACS_B_KIND];
        s_d.ctrl.cal_target = link_word.data[ACS_B_TGT +: 2];
        s_d.ptr = first_ptr(link_word.data[ACS_B_TGT +: 2]);
        // A launch written while a calibration still runs is ignored
        if (s_q.step == ACS_ST_IDLE) begin
          s_d.ctrl.cal_launch = link_word.data[ACS_B_LAUNCH];
          if (link_word.data[ACS_B_LAUNCH]) begin
            s_d.step = first_step(link_word.data[ACS_B_TGT +: 2]);
            s_d.cal_tgt = link_word.data[ACS_B_TGT +: 2];
            s_d.cal_sys = link_word.data[ACS_B_KIND];
            s_d.step_cnt = '0;
            s_d.sub = '0;
          end
        end
        if (link_word.data[ACS_B_CONV] && !s_q.conv) begin
          s_d.conv = 1'b1;
          s_d.conv_cnt = '0;
        end
      end
    end

    s_d.busy = s_d.conv || s_d.step != ACS_ST_IDLE;
    // Frozen while a frame is open: the link samples it on its own clock
    if (s_q.fr_s[1]) begin
      s_d.rd_word = read_word(s_d);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_q = s_q.busy;
  assign cal_step_q = s_q.step;
  assign cal_system_q = s_q.cal_sys;
  assign power_saving_q = s_q.ctrl.power_saving;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_left(acs_step_t st);
    $past(s_q.step) == st && s_q.step != st;
  endsequence

  sequence seq_started;
    $past(s_q.step) == ACS_ST_IDLE && s_q.step != ACS_ST_IDLE;
  endsequence

  sequence seq_status_view;
    s_q.fr_s[1] ##1 s_q.ctrl.readback_select == ACS_RD_STATUS;
  endsequence

  chk_launch_running: assert property (s_q.ctrl.cal_launch == (s_q.step != ACS_ST_IDLE))
    else $error("launch bit disagrees with calibration activity");

  chk_status_const: assert property (seq_status_view |-> s_q.rd_word[15] == 1'b0 &&
      s_q.rd_word[13:10] == 4'h0 && s_q.rd_word[7:6] == ACS_STAT_ID && s_q.rd_word[4] == 1'b0)
    else $error("status constant bits wrong");

  chk_status_live: assert property (seq_status_view |-> s_q.rd_word[14] == s_q.busy &&
      s_q.rd_word[3:0] == {s_q.ctrl.cal_kind_select, s_q.ctrl.cal_target, s_q.ctrl.cal_launch} &&
      s_q.rd_word[9:8] == s_q.ctrl.power_saving)
    else $error("status live bits wrong");

  chk_mode_clear: assert property (ev && link_word.addr != ACS_ADDR_CTRL |=> !s_q.ctrl.mode)
    else $error("mode bit not cleared after read cycle");

  chk_ptr_reset: assert property (ev && link_word.addr == ACS_ADDR_CTRL |=>
      s_q.ptr == first_ptr(s_q.ctrl.cal_target))
    else $error("pointer not reset by control write");

  chk_coef_write: assert property (cal_wr |=> s_q.coef[$past(s_q.ptr)] == $past(link_word.data))
    else $error("coefficient write lost");

  chk_first_step: assert property (seq_started |-> s_q.step == first_step(s_q.cal_tgt) &&
      s_q.cal_sys == $past(link_word.data[ACS_B_KIND]))
    else $error("calibration started in wrong step");

  chk_after_dac: assert property (seq_left(ACS_ST_DAC) |-> s_q.step == ACS_ST_GAIN &&
      $past(s_q.sub) == ACS_DAC_LAST_SUB)
    else $error("DAC step left early or to wrong step");

  chk_after_gain: assert property (seq_left(ACS_ST_GAIN) |-> s_q.step ==
      ((s_q.cal_tgt == ACS_TGT_GAIN) ? ACS_ST_IDLE : ACS_ST_OFFSET))
    else $error("gain step followed by wrong step");

  chk_step_length: assert property ($changed(s_q.step) && $past(s_q.step) != ACS_ST_IDLE |->
      $past(s_q.step_cnt) == STEP_LAST)
    else $error("calibration step ended at wrong count");

  sequence seq_cal_done;
    $past(s_q.step) != ACS_ST_IDLE && s_q.step == ACS_ST_IDLE;
  endsequence

  // Every run ends on offset, except a gain-only run
  chk_last_step: assert property (seq_cal_done |-> $past(s_q.step) ==
      ((s_q.cal_tgt == ACS_TGT_GAIN) ? ACS_ST_GAIN : ACS_ST_OFFSET))
    else $error("calibration ended after wrong step");

  chk_launch_end: assert property ($fell(s_q.ctrl.cal_launch) |-> s_q.step == ACS_ST_IDLE &&
      $past(s_q.step_cnt) == STEP_LAST)
    else $error("launch bit cleared before calibration end");

  chk_conv_length: assert property ($fell(s_q.conv) |-> $past(s_q.conv_cnt) == CONV_LAST)
    else $error("conversion ended at wrong count");

  chk_ptr_subset: assert property (s_q.ptr >= first_ptr(s_q.ctrl.cal_target) &&
      s_q.ptr <= last_ptr(s_q.ctrl.cal_target))
    else $error("coefficient pointer outside selected subset");

  chk_sub_idle: assert property (s_q.step != ACS_ST_DAC |-> s_q.sub == 3'h0)
    else $error("DAC substep count left over");

  // The link samples this word on its own clock, so it must not move inside a frame
  chk_rd_frozen: assert property (!s_q.fr_s[1] |=> $stable(s_q.rd_word))
    else $error("readback word changed inside a frame");

  chk_step_bound: assert property (s_q.step != ACS_ST_IDLE |-> s_q.step_cnt <= STEP_LAST)
    else $error("calibration step counter overran");

endmodule : acs_core

// [acs_host.sv]
`timescale 1ns/1ps
module acs_host (
  output logic sclk,
  output logic frame_n,
  output logic din,
  input wire logic dout
);
  import acs_pkg::*;
  localparam realtime HALF = 62.5;
  initial begin
    sclk = 1'b0;
    frame_n = 1'b1;
    din = 1'b1;
  end
  // Serial clock runs only inside a frame; one word each way, MSB first
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = '0;
    frame_n = 1'b0;
    #100;
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
      r = {r[14:0], dout};
    end
    #20 frame_n = 1'b1;
    // Released data line must not look like a held bit
    din = ~din;
    // Gap well above six core cycles so the next readback word is ready
    #250;
  endtask : xfer
endmodule : acs_host

// [acs_core_tb.sv]
`timescale 1ns/1ps
module acs_core_tb;
  import acs_pkg::*;
  localparam int CONV_N = 400;
  localparam int STEP_N = 400;
  localparam int NCOEF [4] = '{10, 2, 1, 1};
  localparam logic [5:0] ORDER [4] = '{{ACS_ST_DAC, ACS_ST_GAIN, ACS_ST_OFFSET}, {2'h0, ACS_ST_GAIN, ACS_ST_OFFSET},
                                       {4'h0, ACS_ST_OFFSET}, {4'h0, ACS_ST_GAIN}};
  logic clk, resetn, sclk, frame_n, din, dout, busy_q, cal_system_q;
  logic [ACS_ADC_W-1:0] adc_code;
  logic [ACS_DATA_W-1:0] cal_measure;
  logic [1:0] power_saving_q;
  logic [5:0] seq;
  logic [15:0] w;
  acs_step_t cal_step_q, prev_step;
  int mismatches, n_compared;

  acs_core #(.CONV_CYCLES(CONV_N), .STEP_CYCLES(STEP_N)) DUT (
    .clk(clk), .resetn(resetn), .sclk(sclk), .frame_n(frame_n), .din(din), .dout(dout),
    .adc_code(adc_code), .cal_measure(cal_measure), .busy_q(busy_q), .cal_step_q(cal_step_q),
    .cal_system_q(cal_system_q), .power_saving_q(power_saving_q)
  );
  acs_host u_host (.sclk(sclk), .frame_n(frame_n), .din(din), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Record the order in which calibration steps are entered; a run from idle starts a fresh record
  always @(posedge clk) begin
    prev_step <= cal_step_q;
    if (cal_step_q !== ACS_ST_IDLE && prev_step === ACS_ST_IDLE) seq <= {4'h0, cal_step_q};
    else if (cal_step_q !== ACS_ST_IDLE && cal_step_q !== prev_step) seq <= {seq[3:0], cal_step_q};
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] word);
    logic [15:0] r;
    u_host.xfer(word, r);
  endtask : wr

  task automatic xchk(input logic [15:0] word, input logic [15:0] exp);
    logic [15:0] r;
    u_host.xfer(word, r);
    check(r, exp);
  endtask : xchk

  task automatic wait_idle();
    for (int i = 0; i < 5000 && busy_q !== 1'b0; i++) begin
      @(posedge clk);
      #2;
    end
    check({15'h0, busy_q}, 16'h0000);
  endtask : wait_idle

  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #2_000_000;
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [13:0] v;
    resetn = 1'b0;
    adc_code = 12'hA5C;
    cal_measure = 14'h2000;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (10) @(posedge clk);
    #2;
    check({10'h0, busy_q, cal_system_q, power_saving_q, cal_step_q}, 16'h0000);
    xchk(16'h0000, 16'h0000);
    // Status readback, power saving 10, mode 1, system kind, target 01
    wr(16'hC2EA);
    // Frame in an unused address space changes nothing in the status but clears mode bit 5
    xchk(16'h7FFF, 16'h02EA);
    xchk(16'h0000, 16'h02CA);
    check({14'h0, power_saving_q}, 16'h0002);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      #2 cal_measure = 14'h2100 + 14'(c);
      w = 16'hC0C1 | {12'h0, c[2:0], 1'b0};
      wr(w);
      wr(16'h0000);
      // Status carries no address bits: bit 15 reads zero, bit 14 shows busy
      xchk(16'h0000, {2'b01, w[13:0]});
      wait_idle();
      wr(16'h0000);
      xchk(16'h0000, {2'b00, w[13:1], 1'b0});
      check({10'h0, seq}, {10'h0, ORDER[c[1:0]]});
      check({15'h0, cal_system_q}, {15'h0, c[2]});
    end
    // Last gain update came from run 7, last offset update from run 6
    wr(16'hC086);
    xchk(16'h0000, 16'h2107);
    wr(16'hC084);
    xchk(16'h0000, 16'h2106);
    for (int t = 0; t < 4; t++) begin
      wr({ACS_ADDR_CTRL, 11'h0, t[1:0], 1'b0});
      // All writes of a subset first, then all reads
      for (int i = 0; i < NCOEF[t]; i++) begin
        v = {6'h3C, t[1:0], 2'b00, i[3:0]};
        wr({ACS_ADDR_CAL, v});
      end
      wr({ACS_ADDR_CTRL, 6'h0, ACS_RD_CAL, 3'h0, t[1:0], 1'b0});
      // One read past the end shows the pointer wrapping to the first
      for (int i = 0; i <= NCOEF[t]; i++) begin
        v = {6'h3C, t[1:0], 2'b00, 4'(i % NCOEF[t])};
        xchk(16'h0000, {2'b00, v});
      end
    end
    wr(16'hC0D0);
    wr(16'h0000);
    xchk(16'h0000, 16'h40C0);
    wait_idle();
    wrap_up();
  end
endmodule : acs_core_tb
